// >>> include/scs_pkg.sv
// constants for the system clock select and external oscillator block
package scs_pkg;
    // ======================================================
    // register addresses (8-bit special function space)
    localparam logic [7:0] ADDR_SYS_CLK_SEL = 8'h8f;
    localparam logic [7:0] ADDR_EXT_OSC_CTL = 8'hb6;
    localparam logic [7:0] ADDR_HF_OSC_CTL  = 8'hb7;
    localparam logic [7:0] ADDR_LF_OSC_CTL  = 8'had;
    // ======================================================
    // reset values
    localparam logic [7:0] RST_SYS_CLK_SEL  = 8'h00;
    localparam logic [7:0] RST_EXT_OSC_CTL  = 8'h00;
    localparam logic [1:0] RST_HF_DIV       = 2'h0;
    localparam logic [1:0] RST_LF_DIV       = 2'h0;
    // ======================================================
    // field positions
    localparam int SEL_SRC_LSB  = 0;
    localparam int SEL_DIV_LSB  = 4;
    localparam int XOSC_FCN_LSB = 0;
    localparam int XOSC_MD_LSB  = 4;
    localparam int XOSC_VLD_BIT = 7;
    localparam int OSC_DIV_LSB  = 0;
    // ======================================================
    // source select codes
    localparam logic [2:0] SRC_HF  = 3'h0;
    localparam logic [2:0] SRC_EXT = 3'h1;
    localparam logic [2:0] SRC_LF  = 3'h2;
    localparam logic [2:0] SRC_PLL = 3'h4;
    // ======================================================
    // external oscillator modes
    localparam logic [2:0] XMD_CMOS    = 3'h2;
    localparam logic [2:0] XMD_CMOS_D2 = 3'h3;
    localparam logic [2:0] XMD_RC      = 3'h4;
    localparam logic [2:0] XMD_CAP     = 3'h5;
    localparam logic [2:0] XMD_XTAL    = 3'h6;
    localparam logic [2:0] XMD_XTAL_D2 = 3'h7;
    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SYNC_SETTLE_CY = 2;
endpackage

// >>> core/scs_clock_select.sv
// system clock source select, output divider and external oscillator control
`timescale 1ns/10ps
// Function
// - hf oscillator may be enabled and selected in one write, no wait
// - hardware sets crystal valid flag once the external oscillator settled
// - hardware sets pll locked flag once the pll has locked
// - source changes on the fly; software selects only settled sources
// - external oscillator stays available for timers and counter array
// - select codes: 000 hf, 001 ext, 010 lf, 100 pll; rest reserved
// - output divide field 00,01,10,11 gives divide by 1,2,4,8
// - select register bits 7, 6 and 3 read zero
// - crystal valid reads 1 only in crystal modes when stable
// - mode field: off, cmos, cmos/2, rc, cap, crystal, crystal/2
// - external control bit 3 reads zero, writes ignored
// - crystal mode uses both pins, off mode neither, other modes only output pin
// - hf divider 00,01,10,11 gives divide by 8,4,2,1
// - lf divider 00,01,10,11 gives divide by 8,4,2,1
module scs_clock_select (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // divider settings from the oscillator control registers
    input  wire logic [1:0] hf_osc_divider,
    input  wire logic [1:0] lf_osc_divider,
    // source clock ticks, one-cycle enables on clk_sys
    input  wire logic       hf_osc_tick,
    input  wire logic       lf_osc_tick,
    input  wire logic       ext_osc_tick,
    input  wire logic       pll_tick,
    // status from the analog side
    input  wire logic       xtal_amp_ok,
    input  wire logic       pll_lock_raw,
    // generated clock enables
    output logic            system_clock_en,
    output logic            clock_output_en,
    output logic            ext_clock_en,
    // pin ownership and status
    output logic            crystal_input_pin_claim,
    output logic            crystal_output_pin_claim,
    output logic            pll_locked_flag,
    output logic      [2:0] active_source
);
    // ======================================================
    // registers
    logic [2:0] sys_source_select_q;
    logic [1:0] clock_output_divide_q;
    logic [2:0] ext_osc_mode_q;
    logic [2:0] ext_osc_freq_range_q;
    logic       crystal_valid_flag;
    logic [2:0] xv_sync_q;
    logic [2:0] pl_sync_q;
    logic       xtal_mode;
    logic       ext_on;

    function automatic logic [2:0] div_limit(input logic [1:0] code);
        // code 00 divides by 8 down to 11 dividing by 1
        div_limit = 3'h7 >> code;
    endfunction

    function automatic logic src_code_ok(input logic [2:0] code);
        src_code_ok = (code == scs_pkg::SRC_HF) || (code == scs_pkg::SRC_EXT)
                   || (code == scs_pkg::SRC_LF) || (code == scs_pkg::SRC_PLL);
    endfunction

    assign xtal_mode = (ext_osc_mode_q[2:1] == scs_pkg::XMD_XTAL[2:1]);
    assign ext_on    = (ext_osc_mode_q[2:1] != 2'h0);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sys_source_select_q   <= scs_pkg::RST_SYS_CLK_SEL[2:0];
            clock_output_divide_q <= scs_pkg::RST_SYS_CLK_SEL[5:4];
        end else if (reg_wr && reg_addr == scs_pkg::ADDR_SYS_CLK_SEL) begin
            // select takes effect at once, no settle wait
            if (src_code_ok(reg_wdata[2:0]))
                sys_source_select_q <= reg_wdata[2:0];
            clock_output_divide_q <= reg_wdata[5:4];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_osc_mode_q       <= scs_pkg::RST_EXT_OSC_CTL[6:4];
            ext_osc_freq_range_q <= scs_pkg::RST_EXT_OSC_CTL[2:0];
        end else if (reg_wr && reg_addr == scs_pkg::ADDR_EXT_OSC_CTL) begin
            ext_osc_mode_q       <= reg_wdata[6:4];
            ext_osc_freq_range_q <= reg_wdata[2:0];
        end
    end

    // ======================================================
    // status synchronisers, three stages, second and third agree
    // valid flag from settled amplitude
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xv_sync_q       <= 3'h0;
            pl_sync_q       <= 3'h0;
            pll_locked_flag <= 1'b0;
        end else begin
            xv_sync_q <= {xv_sync_q[1:0], xtal_amp_ok};
            pl_sync_q <= {pl_sync_q[1:0], pll_lock_raw};
            if (pl_sync_q[2] == pl_sync_q[1])
                pll_locked_flag <= pl_sync_q[2];
        end
    end

    logic xv_stable_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            xv_stable_q <= 1'b0;
        else if (xv_sync_q[2] == xv_sync_q[1])
            xv_stable_q <= xv_sync_q[2];
    end
    assign crystal_valid_flag = xv_stable_q && xtal_mode;

    // ======================================================
    // external oscillator, with optional divide by 2
    // ext clock runs whatever the system source
    logic ext_half_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_half_q   <= 1'b0;
            ext_clock_en <= 1'b0;
        end else begin
            if (ext_on && ext_osc_tick)
                ext_half_q <= ~ext_half_q;
            // only modes 011 and 111 halve; 101 runs at full rate
            ext_clock_en <= ext_on && ext_osc_tick
                         && (!(ext_osc_mode_q[1] && ext_osc_mode_q[0])
                             || ext_half_q);
        end
    end

    // ======================================================
    // internal oscillator post dividers
    // hf and lf dividers
    logic [2:0] hf_cnt_q;
    logic [2:0] lf_cnt_q;
    logic       hf_en;
    logic       lf_en;
    assign hf_en = hf_osc_tick && (hf_cnt_q == div_limit(hf_osc_divider));
    assign lf_en = lf_osc_tick && (lf_cnt_q == div_limit(lf_osc_divider));
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hf_cnt_q <= 3'h0;
            lf_cnt_q <= 3'h0;
        end else begin
            if (hf_osc_tick)
                hf_cnt_q <= hf_en ? 3'h0 : hf_cnt_q + 3'h1;
            if (lf_osc_tick)
                lf_cnt_q <= lf_en ? 3'h0 : lf_cnt_q + 3'h1;
        end
    end

    // ======================================================
    // source mux; switching at an enable boundary avoids runt periods
    // on-the-fly switch
    logic src_en;
    always_comb begin
        case (active_source)
            scs_pkg::SRC_HF:  src_en = hf_en;
            scs_pkg::SRC_EXT: src_en = ext_clock_en;
            scs_pkg::SRC_LF:  src_en = lf_en;
            scs_pkg::SRC_PLL: src_en = pll_tick;
            default:          src_en = hf_en;
        endcase
    end

    logic       pending;
    assign pending = (active_source != sys_source_select_q);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            active_source   <= scs_pkg::SRC_HF;
            system_clock_en <= 1'b0;
        end else begin
            system_clock_en <= src_en;
            // swap only right after a completed period of the old source
            if (pending && (src_en || system_clock_en))
                active_source <= sys_source_select_q;
        end
    end

    // ======================================================
    // clock output divider
    // divide by 1,2,4,8
    logic [2:0] out_cnt_q;
    logic [2:0] out_lim;
    // terminal count 0,1,3,7 for codes 00..11
    assign out_lim = div_limit(~clock_output_divide_q);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_cnt_q       <= 3'h0;
            clock_output_en <= 1'b0;
        end else begin
            clock_output_en <= 1'b0;
            if (system_clock_en) begin
                if (out_cnt_q >= out_lim) begin
                    out_cnt_q       <= 3'h0;
                    clock_output_en <= 1'b1;
                end else begin
                    out_cnt_q <= out_cnt_q + 3'h1;
                end
            end
        end
    end

    // ======================================================
    // pin ownership
    // crystal uses both pins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            crystal_input_pin_claim  <= 1'b0;
            crystal_output_pin_claim <= 1'b0;
        end else begin
            crystal_input_pin_claim  <= xtal_mode;
            crystal_output_pin_claim <= ext_on;
        end
    end

    // ======================================================
    // readback
    // reserved select bits zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                scs_pkg::ADDR_SYS_CLK_SEL:
                    reg_rdata <= {2'h0, clock_output_divide_q, 1'b0,
                                  sys_source_select_q};
                scs_pkg::ADDR_EXT_OSC_CTL:
                    reg_rdata <= {crystal_valid_flag, ext_osc_mode_q, 1'b0,
                                  ext_osc_freq_range_q};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // ======================================================
    // checks
    chk_reserved_select: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && reg_addr == scs_pkg::ADDR_SYS_CLK_SEL
         && !src_code_ok(reg_wdata[2:0]))
        |=> $stable(sys_source_select_q))
        else $error("reserved source code was taken");

    chk_select_read_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == scs_pkg::ADDR_SYS_CLK_SEL
        |-> reg_rdata[7:6] == 2'h0 && !reg_rdata[3])
        else $error("reserved select bits not zero");

    chk_ctl_bit3_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == scs_pkg::ADDR_EXT_OSC_CTL
        |-> !reg_rdata[3])
        else $error("control bit 3 not zero");

    chk_valid_mode_only: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == scs_pkg::ADDR_EXT_OSC_CTL
        && $past(ext_osc_mode_q[2:1]) != 2'h3
        |-> !reg_rdata[7])
        else $error("valid flag read outside crystal mode");

    sequence s_xtal_stable;
        (xtal_mode && xtal_amp_ok) [*5];
    endsequence
    chk_valid_sets: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_xtal_stable |-> crystal_valid_flag)
        else $error("valid flag not set after settle");

    chk_lock_sets: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        pll_lock_raw [*5] |-> pll_locked_flag)
        else $error("lock flag not set");

    chk_pin_claim: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        crystal_input_pin_claim |-> crystal_output_pin_claim)
        else $error("input pin claimed without output pin");

    chk_hf_select_one_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && reg_addr == scs_pkg::ADDR_SYS_CLK_SEL
         && reg_wdata[2:0] == scs_pkg::SRC_HF)
        |=> sys_source_select_q == scs_pkg::SRC_HF)
        else $error("hf select not taken in one write");

    chk_out_div_one: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        clock_output_divide_q == 2'h0 && out_cnt_q == 3'h0
        && system_clock_en && $stable(clock_output_divide_q)
        |=> clock_output_en)
        else $error("divide by one output missing");
endmodule // scs_clock_select

// >>> tb/scs_osc_model.sv
// oscillator, crystal and pll stand-in driving the clock select block
`timescale 1ns/10ps
module scs_osc_model #(
    parameter int EXT_PER = 3,
    parameter int SETTLE  = 20
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // pin claims from the block, pll power from the bench
    input  wire logic xtal_on,
    input  wire logic ext_on,
    input  wire logic pll_on,
    // source ticks and analog status
    output logic      hf_osc_tick,
    output logic      lf_osc_tick,
    output logic      ext_osc_tick,
    output logic      pll_tick,
    output logic      xtal_amp_ok,
    output logic      pll_lock_raw
);
    logic lf_q;
    int   ext_q;
    int   xt_q;
    int   pll_q;
    // ==========================================
    // free running sources
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lf_q  <= 1'b0;
            ext_q <= 0;
        end else begin
            lf_q  <= !lf_q;
            ext_q <= (ext_q >= EXT_PER - 1) ? 0 : ext_q + 1;
        end
    end
    // ==========================================
    // settle only while powered; losing power restarts from zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xt_q  <= 0;
            pll_q <= 0;
        end else begin
            xt_q  <= xtal_on ? ((xt_q < SETTLE) ? xt_q + 1 : xt_q) : 0;
            pll_q <= pll_on ? ((pll_q < SETTLE) ? pll_q + 1 : pll_q) : 0;
        end
    end
    assign hf_osc_tick  = 1'b1;
    assign lf_osc_tick  = lf_q;
    assign pll_tick     = pll_on;
    assign xtal_amp_ok  = (xt_q >= SETTLE);
    assign pll_lock_raw = (pll_q >= SETTLE);
    // analog pair or digital pin
    // a crystal gives no clock until its amplitude has built up
    assign ext_osc_tick = ext_on && ext_q == 0 && (!xtal_on || xtal_amp_ok);
endmodule // scs_osc_model

// >>> tb/system_clock_source_select_xosc_ctrl_test.sv
// self-checking bench for the system clock select block
`timescale 1ns/10ps
module system_clock_source_select_xosc_ctrl_test;
    // stands in for the 1 ms crystal wait, scaled down
    localparam int         XTAL_WAIT = 40;
    localparam logic [7:0] SEL = scs_pkg::ADDR_SYS_CLK_SEL;
    localparam logic [7:0] EXC = scs_pkg::ADDR_EXT_OSC_CTL;
    logic       clk_sys, rst_b, reg_wr, reg_rd, pll_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] hf_div, lf_div;
    logic       hf_t, lf_t, ext_t, pll_t, amp_ok, lock_raw;
    logic       sys_en, out_en, ext_en, in_claim, out_claim, pll_flag;
    logic [2:0] act_src;
    int         err_count, check_count, cyc, n_sys, n_out, n_ext;
    // ==========================================
    // clock, partner and block
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    scs_osc_model u_osc (.clk_sys(clk_sys), .rst_b(rst_b),
        .xtal_on(in_claim), .ext_on(out_claim), .pll_on(pll_on),
        .hf_osc_tick(hf_t), .lf_osc_tick(lf_t), .ext_osc_tick(ext_t),
        .pll_tick(pll_t), .xtal_amp_ok(amp_ok), .pll_lock_raw(lock_raw));
    scs_clock_select u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hf_osc_divider(hf_div),
        .lf_osc_divider(lf_div), .hf_osc_tick(hf_t), .lf_osc_tick(lf_t),
        .ext_osc_tick(ext_t), .pll_tick(pll_t), .xtal_amp_ok(amp_ok),
        .pll_lock_raw(lock_raw), .system_clock_en(sys_en),
        .clock_output_en(out_en), .ext_clock_en(ext_en),
        .crystal_input_pin_claim(in_claim),
        .crystal_output_pin_claim(out_claim),
        .pll_locked_flag(pll_flag), .active_source(act_src));
    // ==========================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // pulse counts may straddle the window edge by one
    task automatic near(input string what, input int seen, input int exp);
        chk(what, (seen >= exp - 1 && seen <= exp + 1) ? 16'(exp)
            : 16'(seen), 16'(exp));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
        chk(what, 16'(reg_rdata), 16'(exp));
    endtask
    task automatic count(input int n);
        n_sys = 0;
        n_out = 0;
        n_ext = 0;
        repeat (n) begin
            @(negedge clk_sys);
            n_sys += int'(sys_en);
            n_out += int'(out_en);
            n_ext += int'(ext_en);
        end
    endtask
    task automatic wait_src(input logic [2:0] s);
        for (int i = 0; i < 60 && act_src !== s; i++) @(negedge clk_sys);
        chk("active source", 16'(act_src), 16'(s));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        rchk(SEL, 8'h00, "select reset");
        rchk(EXC, 8'h00, "ext control reset");
        rchk(8'h55, 8'h00, "unmapped read");
        chk("reset source", 16'(act_src), 16'(scs_pkg::SRC_HF));
        chk("pin claims", {in_claim, out_claim}, 16'h0);
        wr(SEL, 8'hff);
        rchk(SEL, 8'h30, "select reserved bits");
        chk("reserved code keeps source", 16'(act_src), 16'h0);
        wr(EXC, 8'h1f);
        rchk(EXC, 8'h17, "ext bit 3");
        chk("pins off mode", {in_claim, out_claim}, 16'h0);
        $display("test reset and reserved done");
    endtask
    task automatic t_div();
        wr(SEL, 8'h00);
        wait_src(scs_pkg::SRC_HF);
        for (int d = 0; d < 4; d++) begin
            hf_div = 2'(d);
            repeat (20) @(negedge clk_sys);
            count(128);
            near("hf divided clock", n_sys, 128 >> (3 - d));
        end
        wr(SEL, {5'h0, scs_pkg::SRC_LF});
        wait_src(scs_pkg::SRC_LF);
        for (int d = 0; d < 4; d++) begin
            lf_div = 2'(d);
            repeat (20) @(negedge clk_sys);
            count(128);
            near("lf divided clock", n_sys, 64 >> (3 - d));
        end
        wr(SEL, 8'h00);
        wait_src(scs_pkg::SRC_HF);
        for (int c = 0; c < 4; c++) begin
            wr(SEL, {2'b00, 2'(c), 4'h0});
            rchk(SEL, {2'b00, 2'(c), 4'h0}, "output divide field");
            repeat (20) @(negedge clk_sys);
            count(128);
            near("output divided clock", n_out, 128 >> c);
        end
        $display("test dividers done");
    endtask
    task automatic t_ext();
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            // range 111 suits the fast crystal stand-in
            wr(EXC, {1'b0, m, 4'h7});
            repeat (2) @(negedge clk_sys);
            chk("input pin claim", in_claim, m[2:1] == 2'b11);
            chk("output pin claim", out_claim, m[2:1] != 2'b00);
            if (m == scs_pkg::XMD_XTAL) begin
                rchk(EXC, {1'b0, m, 4'h7}, "valid before settle");
                repeat (XTAL_WAIT) @(negedge clk_sys);
                rchk(EXC, {1'b1, m, 4'h7}, "valid after settle");
                wr(SEL, {5'h0, scs_pkg::SRC_EXT});
                wait_src(scs_pkg::SRC_EXT);
                count(120);
                near("ext system clock", n_sys, 40);
                wr(SEL, 8'h00);
                wait_src(scs_pkg::SRC_HF);
            end
            if (m[2:1] != 2'b00) begin
                count(120);
                // only 011 and 111 halve the external clock
                near("ext timer clock", n_ext, (m[1] && m[0]) ? 20 : 40);
            end
        end
        wr(EXC, {1'b0, scs_pkg::XMD_RC, 4'h7});
        rchk(EXC, {1'b0, scs_pkg::XMD_RC, 4'h7}, "valid in rc mode");
        $display("test external oscillator done");
    endtask
    task automatic t_pll();
        pll_on = 1'b1;
        chk("lock flag early", pll_flag, 1'b0);
        for (int i = 0; i < 60 && pll_flag !== 1'b1; i++) @(negedge clk_sys);
        chk("lock flag", pll_flag, 1'b1);
        wr(SEL, {5'h0, scs_pkg::SRC_PLL});
        wait_src(scs_pkg::SRC_PLL);
        count(64);
        near("pll system clock", n_sys, 64);
        wr(SEL, 8'h03);
        repeat (10) @(negedge clk_sys);
        chk("reserved code", 16'(act_src), 16'(scs_pkg::SRC_PLL));
        $display("test pll done");
    endtask
    // ==========================================
    // main sequence and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_b, reg_wr, reg_rd, pll_on, reg_addr, reg_wdata} = '0;
        {hf_div, lf_div, err_count, check_count, cyc} = '0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        t_reset();
        t_div();
        t_ext();
        t_pll();
        tally_and_finish();
    end
endmodule // system_clock_source_select_xosc_ctrl_test
